// [self_test_pkg.sv]
// Constants for the self-test and status LED supervisor
package self_test_pkg;
    localparam int unsigned CLK_HZ          = 100_000_000;
    localparam int unsigned CLK_PERIOD_NS   = 10;
    // Blink period in milliseconds
    localparam int unsigned BLINK_PERIOD_MS = 1000;
    localparam int unsigned BLINK_HALF_CYC  = (BLINK_PERIOD_MS * 1000 / 2) * (1000 / CLK_PERIOD_NS);
    // Self-test run length and poll interval, in cycles
    localparam int unsigned TEST_CYC        = 4096;
    localparam int unsigned POLL_GAP_CYC    = 1024;
    localparam int unsigned POLL_TIMEOUT_CYC = 2048;
    localparam int unsigned DRIVES          = 8;
endpackage : self_test_pkg

// [status_led_self_test_supervisor.sv]
// Self-test supervisor, drive status poller and status LED driver
module status_led_self_test_supervisor #(
    parameter int unsigned BLINK_HALF = self_test_pkg::BLINK_HALF_CYC,
    parameter int unsigned TEST_LEN   = self_test_pkg::TEST_CYC,
    parameter int unsigned POLL_GAP   = self_test_pkg::POLL_GAP_CYC,
    parameter int unsigned POLL_WAIT  = self_test_pkg::POLL_TIMEOUT_CYC,
    parameter int unsigned DRIVES     = self_test_pkg::DRIVES
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              board_reset_switch,
    input  wire logic              testDone,
    input  wire logic              testPass,
    input  wire logic [DRIVES-1:0] driveAssigned,
    input  wire logic              pollAnswer,
    input  wire logic              pollPresent,
    input  wire logic              transferActive,
    input  wire logic              hostAccessReq,
    output logic                   hostAccessGrant,
    output logic                   testRunning,
    output logic                   testFailed,
    output logic                   pollStrobe,
    output logic [2:0]             pollDrive,
    output logic                   driveFault,
    output logic                   statusLed
);
    typedef enum logic [2:0] {
        TESTING = 3'b001,
        RUNNING = 3'b010,
        FAILED  = 3'b100
    } mode_e;

    localparam int unsigned TW = $clog2(TEST_LEN + 1);
    localparam int unsigned BW = $clog2(BLINK_HALF + 1);
    localparam int unsigned PW = $clog2(POLL_GAP + POLL_WAIT + 1);

    mode_e             mode, next_mode;
    logic [TW-1:0]     testCnt, next_testCnt;
    logic [BW-1:0]     blinkCnt, next_blinkCnt;
    logic              blinkPhase, next_blinkPhase;
    logic [PW-1:0]     pollCnt, next_pollCnt;
    logic              pollWaiting, next_pollWaiting;
    logic [2:0]        next_pollDrive;
    logic [DRIVES-1:0] silent, next_silent;
    logic              ledNext;

    // Switch closed equals reset asserted
    wire logic localReset = rst | board_reset_switch;

    // Next assigned drive after the given one, wrapping through the index space
    function automatic logic [2:0] nextDrive(input logic [2:0] cur, input logic [DRIVES-1:0] asg);
        logic [2:0] d;
        logic [2:0] cand;
        logic       found;
        d     = cur;
        cand  = cur;
        found = 1'b0;
        for (int i = 1; i <= DRIVES; i++) begin
            cand = 3'(cur + 3'(i));
            if (!found && asg[cand]) begin
                d     = cand;
                found = 1'b1;
            end
        end
        return d;
    endfunction : nextDrive

    // Running mode decode, shared by LED, fault and host gate
    function automatic logic isRunning(input mode_e m);
        return (m == RUNNING);
    endfunction : isRunning

    always_comb begin
        next_mode       = mode;
        next_testCnt    = testCnt;
        next_blinkCnt   = blinkCnt;
        next_blinkPhase = blinkPhase;
        next_pollCnt    = pollCnt;
        next_pollWaiting = pollWaiting;
        next_pollDrive  = pollDrive;
        next_silent     = silent;
        pollStrobe      = 1'b0;
        unique case (mode)
            TESTING: begin
                // Test ends on report or on run-length expiry (counted as fail)
                if (testDone) begin
                    next_mode = testPass ? RUNNING : FAILED;
                end else if (testCnt == TW'(TEST_LEN)) begin
                    next_mode = FAILED;
                end else begin
                    next_testCnt = testCnt + TW'(1);
                end
            end
            RUNNING: begin
                // Continuous round-robin poll of assigned drives
                if (!pollWaiting) begin
                    if (pollCnt >= PW'(POLL_GAP)) begin
                        pollStrobe       = 1'b1;
                        next_pollWaiting = 1'b1;
                        next_pollCnt     = '0;
                    end else begin
                        next_pollCnt = pollCnt + PW'(1);
                    end
                end else if (pollAnswer) begin
                    next_silent[pollDrive] = 1'b0;
                    next_pollWaiting       = 1'b0;
                    next_pollDrive         = nextDrive(pollDrive, driveAssigned);
                end else if (pollCnt >= PW'(POLL_WAIT)) begin
                    next_silent[pollDrive] = 1'b1;
                    next_pollWaiting       = 1'b0;
                    next_pollCnt           = '0;
                    next_pollDrive         = nextDrive(pollDrive, driveAssigned);
                end else begin
                    next_pollCnt = pollCnt + PW'(1);
                end
                next_silent = next_silent & driveAssigned;
            end
            FAILED: begin
            end
        endcase
        // Equal on and off halves of the blink
        if (blinkCnt == BW'(BLINK_HALF - 1)) begin
            next_blinkCnt   = '0;
            next_blinkPhase = ~blinkPhase;
        end else begin
            next_blinkCnt = blinkCnt + BW'(1);
        end
        // LED priority: test/fail, activity, blink, off
        if (!isRunning(mode)) begin
            ledNext = 1'b1;
        end else if (transferActive) begin
            ledNext = 1'b1;
        end else if (!pollPresent || driveAssigned == '0 || silent != '0) begin
            ledNext = blinkPhase;
        end else begin
            ledNext = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (localReset) begin
            mode        <= TESTING;
            testCnt     <= '0;
            blinkCnt    <= '0;
            blinkPhase  <= 1'b0;
            pollCnt     <= '0;
            pollWaiting <= 1'b0;
            pollDrive   <= 3'h0;
            silent      <= '0;
            statusLed   <= 1'b1;
        end else begin
            mode        <= next_mode;
            testCnt     <= next_testCnt;
            blinkCnt    <= next_blinkCnt;
            blinkPhase  <= next_blinkPhase;
            pollCnt     <= next_pollCnt;
            pollWaiting <= next_pollWaiting;
            pollDrive   <= next_pollDrive;
            silent      <= next_silent;
            statusLed   <= ledNext;
        end
    end

    assign testRunning     = (mode == TESTING);
    assign testFailed      = (mode == FAILED);
    assign driveFault      = (silent != '0) || (isRunning(mode) && (driveAssigned == '0 || !pollPresent));
    // Host access only after a pass
    assign hostAccessGrant = hostAccessReq && isRunning(mode);
endmodule : status_led_self_test_supervisor

// [supervisor_checker.sv]
// Port-level assertions for the self-test supervisor
module supervisor_checker (
    input wire logic clk,
    input wire logic rst,
    input wire logic board_reset_switch,
    input wire logic testDone,
    input wire logic testPass,
    input wire logic pollPresent,
    input wire logic transferActive,
    input wire logic hostAccessReq,
    input wire logic hostAccessGrant,
    input wire logic testRunning,
    input wire logic testFailed,
    input wire logic pollStrobe,
    input wire logic driveFault,
    input wire logic statusLed
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst || board_reset_switch);
    sequence pollSoon; ##[0:20] pollStrobe; endsequence
    chk_reset_state: assert property (disable iff (1'b0) (rst || board_reset_switch) |=> statusLed && testRunning)
        else $error("reset state wrong");
    chk_test_lit: assert property (testRunning |=> statusLed)
        else $error("led dark during test");
    chk_pass_leave: assert property (testRunning && testDone && testPass |=> !testRunning && !testFailed)
        else $error("pass not taken");
    chk_fail_enter: assert property (testRunning && testDone && !testPass |=> testFailed && !testRunning)
        else $error("fail not taken");
    chk_fail_sticky: assert property (testFailed |=> testFailed && statusLed)
        else $error("failure not held");
    chk_grant_gate: assert property (hostAccessGrant == (hostAccessReq && !testRunning && !testFailed))
        else $error("grant wrong");
    chk_poll_steady: assert property (!testRunning && !testFailed && pollPresent |-> pollSoon)
        else $error("polling stalled");
    chk_idle_dark: assert property (!testRunning && !testFailed && !transferActive && !driveFault && pollPresent
        |=> !statusLed) else $error("idle led lit");
    chk_activity_lit: assert property (!testRunning && !testFailed && transferActive |=> statusLed)
        else $error("activity not shown");
endmodule : supervisor_checker
bind status_led_self_test_supervisor supervisor_checker chk_u (.*);

// [drive_poll_model.sv]
// Drive-side poll responder; answer delay grows with the low two bits of the drive index
module drive_poll_model (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       pollStrobe,
    input  wire logic [2:0] pollDrive,
    input  wire logic [7:0] answerMask,
    output logic            pollAnswer
);
    logic [2:0] cnt;
    always_ff @(posedge clk) begin
        pollAnswer <= 1'b0;
        if (rst) begin
            cnt <= 3'h0;
        end else if (pollStrobe && answerMask[pollDrive]) begin
            cnt <= {1'b0, pollDrive[1:0]} + 3'h1;
        end else if (cnt != 3'h0) begin
            cnt <= cnt - 3'h1;
            pollAnswer <= (cnt == 3'h1);
        end
    end
endmodule : drive_poll_model

// [testbench.sv]
// Self-checking bench for the self-test supervisor
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, board_reset_switch, testDone, testPass, pollAnswer, pollPresent, transferActive, hostAccessReq;
    logic hostAccessGrant, testRunning, testFailed, pollStrobe, driveFault, statusLed;
    logic [7:0] driveAssigned, answerMask;
    logic [2:0] pollDrive;
    int n_mismatch = 0, n_tests = 0, cycles = 0;
    status_led_self_test_supervisor #(.BLINK_HALF(8), .TEST_LEN(16), .POLL_GAP(4), .POLL_WAIT(8)) dut_u (.*);
    drive_poll_model partner_u (.*);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic check(string nm, logic [7:0] seen, logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic boot(logic sw, logic done, logic pass);
        @(posedge clk);
        if (sw) board_reset_switch <= 1'b1; else rst <= 1'b1;
        repeat (5) @(negedge clk);
        check("resetLed", {statusLed, testRunning, hostAccessGrant}, 8'h06);
        @(posedge clk);
        {rst, board_reset_switch, testDone, testPass} <= {2'b00, done, pass};
        @(posedge clk);
        testDone <= 1'b0;
        repeat (40) @(negedge clk);
        check("failed", testFailed, !(done && pass));
        check("grant", hostAccessGrant, done && pass);
    endtask : boot
    task automatic watch(logic [7:0] exp);
        int lit = 0, polls = 0;
        repeat (3) @(posedge clk);
        repeat (32) @(negedge clk) begin
            lit += (statusLed === 1'b1);
            polls += (pollStrobe === 1'b1);
        end
        check("ledOn", lit[7:0], exp);
        check("polled", polls >= 2, 8'h01);
    endtask : watch
    task automatic print_verdict;
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : print_verdict
    always @(posedge clk) begin
        cycles++;
        if (cycles >= 2000) begin
            n_mismatch++;
            print_verdict;
        end
    end
    initial begin
        {rst, board_reset_switch, testDone, testPass, transferActive} <= 5'h10;
        {pollPresent, hostAccessReq, driveAssigned, answerMask} <= {2'b11, 8'hff, 8'h00};
        boot(1'b1, 1'b1, 1'b0);
        boot(1'b0, 1'b0, 1'b1);
        boot(1'b0, 1'b1, 1'b1);
        watch(8'h10);
        @(posedge clk);
        transferActive <= 1'b1;
        watch(8'h20);
        @(posedge clk);
        {transferActive, answerMask} <= {1'b0, 8'hff};
        repeat (150) @(posedge clk);
        watch(8'h00);
        @(posedge clk);
        pollPresent <= 1'b0;
        watch(8'h10);
        print_verdict;
    end
endmodule : testbench
